/* mcr_pkg.sv */
/*
  Package for the motor configuration register slice: register offsets,
  field positions, reset values, timing constants and the carrier types.
  Assumes a single 50 MHz system clock shared by every user of the package.
*/
package mcr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADDR_SINGLE_ADDRESS  = 8'h33;
  localparam logic [7:0]  ADDR_ACCESS_CONTROL  = 8'h35;
  localparam logic [7:0]  ADDR_SINGLE_READ     = 8'h36;
  localparam logic [7:0]  ADDR_UNUSED_A_FIRST  = 8'h37;
  localparam logic [7:0]  ADDR_UNUSED_A_LAST   = 8'h5f;
  localparam logic [7:0]  ADDR_PROGRAM_CONTROL = 8'h60;
  localparam logic [7:0]  ADDR_UNUSED_B_FIRST  = 8'h61;
  localparam logic [7:0]  ADDR_UNUSED_B_LAST   = 8'h8f;
  localparam logic [7:0]  ADDR_FIRST_CONFIG    = 8'h90;
  localparam logic [7:0]  ADDR_SECOND_CONFIG   = 8'h91;

  localparam logic [15:0] RESET_WORD           = 16'h0000;
  localparam logic [7:0]  RESET_ADDRESS        = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int          BIT_MOTOR_DRIVE_OFF  = 15;
  localparam int          BIT_WRITE_SELECT     = 2;
  localparam int          ACCESS_MODE_LSB      = 0;
  localparam int          SECOND_CONFIG_MSB    = 14;
  localparam logic [14:0] SECOND_CONFIG_RESET  = 15'h0000;

  // Access modes of the nonvolatile memory
  typedef enum logic [1:0] {
    MCR_ACC_OFF    = 2'b00,
    MCR_ACC_SINGLE = 2'b01,
    MCR_ACC_BULK   = 2'b10,
    MCR_ACC_RSVD   = 2'b11
  } mcr_access_mode_e;

  // Tach gating choices
  typedef enum logic [1:0] {
    MCR_TACH_ALWAYS      = 2'b00,
    MCR_TACH_CLOSED_LATE = 2'b01,
    MCR_TACH_FIRST_OPEN  = 2'b10,
    MCR_TACH_RESERVED    = 2'b11
  } mcr_tach_gate_e;

  // Dither span choices
  typedef enum logic [1:0] {
    MCR_DITHER_NONE = 2'b00,
    MCR_DITHER_5    = 2'b01,
    MCR_DITHER_10   = 2'b10,
    MCR_DITHER_15   = 2'b11
  } mcr_dither_e;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ           = 50_000_000;
  localparam int TACH_DELAY_MS    = 280;
  localparam int TACH_DELAY_CYCLES = TACH_DELAY_MS * (CLK_HZ / 1000);
  localparam int TACH_DELAY_WIDTH = 24;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    mcr_dither_e    spread_spectrum_sel;
    mcr_tach_gate_e tach_open_loop_sel;
    logic [3:0]     tach_divide_ratio;
    logic           cycle_adjust_granularity;
    logic [2:0]     resistance_shift;
    logic [3:0]     resistance_mantissa;
  } mcr_first_config_word_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mcr_reg_req_s;

  typedef struct packed {
    logic             start;
    mcr_access_mode_e mode;
    logic             write_select;
    logic [7:0]       address;
  } mcr_nv_cmd_s;

endpackage : mcr_pkg

/* mcr_tach.sv */
/*
  Tach output generator: divides electrical half-cycle edges by n+1 and
  gates the output according to the open-loop select field.
  Assumes edge, loop state and configuration inputs are synchronous to sys_clk.
*/
`timescale 1ns/10ps
module mcr_tach #(
  parameter int DELAY_CYCLES = mcr_pkg::TACH_DELAY_CYCLES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    elec_edge,
  input  wire logic                    closed_loop,
  input  wire logic                    motor_running,
  input  wire logic [3:0]              tach_divide_ratio,
  input  wire mcr_pkg::mcr_tach_gate_e tach_open_loop_sel,
  output logic                         tach_output
);

  logic [3:0]                          edge_count;
  logic                                tach_raw;
  logic [mcr_pkg::TACH_DELAY_WIDTH-1:0] delay_count;
  logic                                delay_done;
  logic                                seen_closed;
  logic                                gate_open;

  localparam logic [mcr_pkg::TACH_DELAY_WIDTH-1:0] DELAY_LAST =
    mcr_pkg::TACH_DELAY_WIDTH'(DELAY_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  // Toggle every n+1 half-cycle edges gives electrical rate over n+1
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_count <= 4'h0;
      tach_raw   <= 1'b0;
    end else if (!motor_running) begin
      edge_count <= 4'h0;
      tach_raw   <= 1'b0;
    end else if (elec_edge) begin
      if (edge_count >= tach_divide_ratio) begin
        edge_count <= 4'h0;
        tach_raw   <= ~tach_raw;
      end else begin
        edge_count <= edge_count + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Gating state
  // ----------------------------------------------------------------------
  // Delay restarts whenever closed loop is lost
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_count <= '0;
      delay_done  <= 1'b0;
    end else if (!closed_loop || !motor_running) begin
      delay_count <= '0;
      delay_done  <= 1'b0;
    end else if (!delay_done) begin
      if (delay_count == DELAY_LAST) begin
        delay_done <= 1'b1;
      end else begin
        delay_count <= delay_count + 1'b1;
      end
    end
  end

  // A spin-up counts as the first open loop until closed loop is reached
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_closed <= 1'b0;
    end else if (!motor_running) begin
      seen_closed <= 1'b0;
    end else if (closed_loop) begin
      seen_closed <= 1'b1;
    end
  end

  // Reserved selection keeps the output quiet
  always_comb begin
    case (tach_open_loop_sel)
      mcr_pkg::MCR_TACH_ALWAYS:      gate_open = 1'b1;
      mcr_pkg::MCR_TACH_CLOSED_LATE: gate_open = closed_loop && delay_done;
      mcr_pkg::MCR_TACH_FIRST_OPEN:  gate_open = closed_loop || !seen_closed;
      default:                       gate_open = 1'b0;
    endcase
  end

  // Registered output
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tach_output <= 1'b0;
    end else begin
      tach_output <= tach_raw && gate_open;
    end
  end

endmodule : mcr_tach

/* mcr_regs.sv */
/*
  Motor configuration register slice: single-location memory access
  registers, the motor disable control and the configuration words, with
  their decoded settings and the tach output.
  Assumes the two-wire serial engine presents one-cycle read and write
  strobes on the register port, and that the memory controller reports a
  finished single read with a one-cycle pulse and its word.
*/
// What this block does
// - Finished single read loads read-data register
// - Read-data register ignores host writes
// - Addresses 0x37 to 0x5F do nothing
// - Addresses 0x61 to 0x8F do nothing
// - Motor-disable bit set stops all drive
// - Motor-disable bit never reads back
// - Bits 15:14 select dither span
// - Bits 13:12 gate the tach output
// - Tach is electrical speed over n+1
// - Bit 7 selects full or half cycle
// - Resistance is mantissa shifted by shift count
// - First configuration word resets to zero
// - Single-access address selects target, 0x90 first word
// - Access mode field and read/write select
`timescale 1ns/10ps
module mcr_regs #(
  parameter int TACH_DELAY_CYCLES = mcr_pkg::TACH_DELAY_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire mcr_pkg::mcr_reg_req_s reg_req,
  output logic [15:0]                reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic                  nv_read_done,
  input  wire logic [15:0]           nv_read_word,
  output mcr_pkg::mcr_nv_cmd_s       nv_cmd,
  output logic                       motor_drive_off,
  output logic                       motor_run_enable,
  output mcr_pkg::mcr_first_config_word_s      first_config,
  output logic [14:0]                second_config,
  output logic [10:0]                resistance_value,
  input  wire logic                  elec_edge,
  input  wire logic                  closed_loop,
  output logic                       tach_output
);

  logic [7:0]                single_access_address;
  mcr_pkg::mcr_access_mode_e memory_access_mode;
  logic                      memory_write_select;
  logic [15:0]               single_read_word;
  logic [15:0]               first_config_word;
  logic [15:0]               next_rdata;
  logic                      hit_address;
  logic                      hit_control;
  logic                      hit_read;
  logic                      hit_program;
  logic                      hit_first;
  logic                      hit_second;
  logic                      start_pulse;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Only listed offsets decode; both unused ranges fall through to nothing.
  // Exact compares keep a stray offset from aliasing onto a live register.
  assign hit_address = reg_req.addr == mcr_pkg::ADDR_SINGLE_ADDRESS;
  assign hit_control = reg_req.addr == mcr_pkg::ADDR_ACCESS_CONTROL;
  assign hit_read    = reg_req.addr == mcr_pkg::ADDR_SINGLE_READ;
  assign hit_program = reg_req.addr == mcr_pkg::ADDR_PROGRAM_CONTROL;
  assign hit_first   = reg_req.addr == mcr_pkg::ADDR_FIRST_CONFIG;
  assign hit_second  = reg_req.addr == mcr_pkg::ADDR_SECOND_CONFIG;

  // ----------------------------------------------------------------------
  // Single-location access setup
  // ----------------------------------------------------------------------
  // Target address for the memory controller
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      single_access_address <= mcr_pkg::RESET_ADDRESS;
    end else if (reg_req.wr && hit_address) begin
      single_access_address <= reg_req.wdata[7:0];
    end
  end

  // Mode and direction; writing this register with a nonzero mode launches an access
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memory_access_mode  <= mcr_pkg::MCR_ACC_OFF;
      memory_write_select <= 1'b0;
    end else if (reg_req.wr && hit_control) begin
      memory_access_mode  <= mcr_pkg::mcr_access_mode_e'(
        reg_req.wdata[mcr_pkg::ACCESS_MODE_LSB +: 2]);
      memory_write_select <= reg_req.wdata[mcr_pkg::BIT_WRITE_SELECT];
    end
  end

  // Start pulse one cycle after the control write, so mode is settled.
  // The reserved mode code still launches a start; the memory controller
  // must refuse it, which keeps this decode to a single compare.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= reg_req.wr && hit_control &&
        (reg_req.wdata[mcr_pkg::ACCESS_MODE_LSB +: 2] != 2'b00);
    end
  end

  // One driver for the whole carrier: pulse plus the stored settings
  assign nv_cmd = '{
    start:        start_pulse,
    mode:         memory_access_mode,
    write_select: memory_write_select,
    address:      single_access_address
  };

  // ----------------------------------------------------------------------
  // Single-read data
  // ----------------------------------------------------------------------
  // Loaded only by the memory controller; host writes are never decoded here
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      single_read_word <= mcr_pkg::RESET_WORD;
    end else if (nv_read_done) begin
      single_read_word <= nv_read_word;
    end
  end

  // ----------------------------------------------------------------------
  // Program control
  // ----------------------------------------------------------------------
  // Drive stays off until software clears the bit again.
  // Reads never show the bit, so software has to remember what it wrote.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      motor_drive_off <= 1'b0;
    end else if (reg_req.wr && hit_program) begin
      motor_drive_off <= reg_req.wdata[mcr_pkg::BIT_MOTOR_DRIVE_OFF];
    end
  end

  assign motor_run_enable = !motor_drive_off;

  // ----------------------------------------------------------------------
  // Configuration words
  // ----------------------------------------------------------------------
  // First word: all fields plain read/write, zero after reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_config_word <= mcr_pkg::RESET_WORD;
    end else if (reg_req.wr && hit_first) begin
      first_config_word <= reg_req.wdata;
    end
  end

  // Second word: top bit reserved, held out of storage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_config <= mcr_pkg::SECOND_CONFIG_RESET;
    end else if (reg_req.wr && hit_second) begin
      second_config <= reg_req.wdata[mcr_pkg::SECOND_CONFIG_MSB:0];
    end
  end

  // Field split follows the packed layout of the carrier
  assign first_config = mcr_pkg::mcr_first_config_word_s'(first_config_word);

  // Rounding is software's job; hardware only rebuilds the value
  assign resistance_value = 11'(first_config.resistance_mantissa) <<
    first_config.resistance_shift;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped and write-only locations read as zero
  always_comb begin
    next_rdata = 16'h0000;
    case (1'b1)
      hit_address: next_rdata = {8'h00, single_access_address};
      hit_control: next_rdata = {13'h0000, memory_write_select, memory_access_mode};
      hit_read:    next_rdata = single_read_word;
      hit_program: next_rdata = 16'h0000;
      hit_first:   next_rdata = first_config_word;
      hit_second:  next_rdata = {1'b0, second_config};
      default:     next_rdata = 16'h0000;
    endcase
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= mcr_pkg::RESET_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tach output
  // ----------------------------------------------------------------------
  // Tach stops with the drive; it goes low two clocks after the disable bit sets
  mcr_tach #(
    .DELAY_CYCLES (TACH_DELAY_CYCLES)
  ) u_tach (
    .sys_clk            (sys_clk),
    .rst_b              (rst_b),
    .elec_edge          (elec_edge),
    .closed_loop        (closed_loop),
    .motor_running      (motor_run_enable),
    .tach_divide_ratio  (first_config.tach_divide_ratio),
    .tach_open_loop_sel (first_config.tach_open_loop_sel),
    .tach_output        (tach_output)
  );

endmodule : mcr_regs

/* mcr_regs_properties.sv */
/*
  Checker for mcr_regs: register port, memory command and tach gating.
  Assumes it is bound to mcr_regs and sees only that module's ports.
*/
`timescale 1ns/10ps
module mcr_regs_properties #(
  parameter int TACH_DELAY_CYCLES = mcr_pkg::TACH_DELAY_CYCLES
) (
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire mcr_pkg::mcr_reg_req_s reg_req,
  input wire logic [15:0]           reg_rdata,
  input wire logic                  reg_rvalid,
  input wire logic                  nv_read_done,
  input wire logic [15:0]           nv_read_word,
  input wire mcr_pkg::mcr_nv_cmd_s  nv_cmd,
  input wire logic                  motor_drive_off,
  input wire logic                  motor_run_enable,
  input wire mcr_pkg::mcr_first_config_word_s first_config,
  input wire logic [14:0]           second_config,
  input wire logic [10:0]           resistance_value,
  input wire logic                  elec_edge,
  input wire logic                  closed_loop,
  input wire logic                  tach_output
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic [15:0] last_word;
  logic        rd_unused;

  // Last finished single read: the only value 0x36 may show
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_word <= 16'h0000;
    end else if (nv_read_done) begin
      last_word <= nv_read_word;
    end
  end

  // Reads of the two unused windows
  assign rd_unused = reg_req.rd && ((reg_req.addr >= 8'h37 && reg_req.addr <= 8'h5f)
                     || (reg_req.addr >= 8'h61 && reg_req.addr <= 8'h8f));

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  read_valid_a: assert property (reg_req.rd |=> reg_rvalid) else $error("no read valid");
  no_valid_a: assert property (!reg_req.rd |=> !reg_rvalid) else $error("stray read valid");
  unused_zero_a: assert property (rd_unused |=> reg_rdata == 16'h0000)
    else $error("unused address read nonzero");
  ctrl_hidden_a: assert property (reg_req.rd && reg_req.addr == 8'h60
    |=> reg_rdata == 16'h0000) else $error("control register read back");
  read_word_a: assert property (reg_req.rd && reg_req.addr == 8'h36
    && !nv_read_done |=> reg_rdata == last_word) else $error("read data word wrong");
  config_write_a: assert property (reg_req.wr && reg_req.addr == 8'h90
    |=> first_config == $past(reg_req.wdata)) else $error("config word not written");
  config_reset_a: assert property ($rose(rst_b) |-> first_config == 16'h0000)
    else $error("config word not zero after reset");
  motor_off_a: assert property (reg_req.wr && reg_req.addr == 8'h60
    |=> motor_drive_off == $past(reg_req.wdata[15]) && motor_run_enable != motor_drive_off)
    else $error("motor disable not applied");
  tach_stop_a: assert property (motor_drive_off [*3] |-> !tach_output)
    else $error("tach active while drive off");
  tach_rsvd_a: assert property (
    (first_config.tach_open_loop_sel == mcr_pkg::MCR_TACH_RESERVED) [*2] |-> !tach_output)
    else $error("tach active in reserved gate");
  resist_calc_a: assert property (resistance_value ==
    ({7'h00, first_config.resistance_mantissa} << first_config.resistance_shift))
    else $error("resistance value wrong");
  cmd_start_a: assert property (reg_req.wr && reg_req.addr == 8'h35
    && reg_req.wdata[1:0] != 2'b00
    |=> nv_cmd.start && nv_cmd.mode == $past(reg_req.wdata[1:0])
    && nv_cmd.write_select == $past(reg_req.wdata[2])) else $error("memory command wrong");
  cmd_idle_a: assert property (reg_req.wr && reg_req.addr == 8'h35
    && reg_req.wdata[1:0] == 2'b00 |=> !nv_cmd.start) else $error("start with access disabled");
  cmd_addr_a: assert property (reg_req.wr && reg_req.addr == 8'h33
    |=> nv_cmd.address == $past(reg_req.wdata[7:0])) else $error("target address wrong");

  cover property (nv_read_done);
  cover property (nv_cmd.start);
  cover property ($rose(tach_output));
endmodule : mcr_regs_properties

bind mcr_regs mcr_regs_properties #(.TACH_DELAY_CYCLES(TACH_DELAY_CYCLES)) u_props (.sys_clk,
  .rst_b, .reg_req, .reg_rdata, .reg_rvalid, .nv_read_done, .nv_read_word, .nv_cmd,
  .motor_drive_off, .motor_run_enable, .first_config, .second_config, .resistance_value,
  .elec_edge, .closed_loop, .tach_output);

/* mcr_nv_model.sv */
/*
  Memory controller model: answers single-location reads, alternately
  promptly and slowly, and counts every command start.
  Assumes nv_cmd comes from mcr_regs on the same clock.
*/
`timescale 1ns/10ps
module mcr_nv_model (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire mcr_pkg::mcr_nv_cmd_s nv_cmd,
  output logic                      nv_read_done,
  output logic [15:0]               nv_read_word,
  output logic [7:0]                n_starts
);
  logic [3:0]  wait_cnt;
  logic        busy;
  logic        slow;
  logic [7:0]  addr_q;
  logic [15:0] noise;

  // Word of location a is {~a, a}; outside the done cycle the word wanders
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {wait_cnt, busy, slow, addr_q, n_starts, nv_read_done} <= '0;
      nv_read_word <= 16'h0000;
      noise        <= 16'h5a3c;
    end else begin
      noise        <= noise + 16'h9e37;
      nv_read_word <= noise;
      nv_read_done <= 1'b0;
      if (nv_cmd.start) begin
        n_starts <= n_starts + 8'h01;
      end
      if (nv_cmd.start && nv_cmd.mode == mcr_pkg::MCR_ACC_SINGLE && !nv_cmd.write_select) begin
        busy     <= 1'b1;
        addr_q   <= nv_cmd.address;
        wait_cnt <= slow ? 4'h6 : 4'h1;
        slow     <= !slow;
      end else if (busy && wait_cnt == 4'h0) begin
        busy         <= 1'b0;
        nv_read_done <= 1'b1;
        nv_read_word <= {~addr_q, addr_q};
      end else if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule : mcr_nv_model

/* testbench.sv */
/*
  Self-checking testbench for mcr_regs with the memory controller model.
  Assumes a 50 MHz clock and a short tach delay parameter.
*/
`timescale 1ns/10ps
module testbench;
  localparam int DLY = 20;
  logic                  sys_clk, rst_b, reg_rvalid, nv_read_done, motor_drive_off;
  logic                  motor_run_enable, elec_edge, closed_loop, tach_output;
  logic                  tach_q = 1'b0;
  logic [15:0]           reg_rdata, nv_read_word, d;
  logic [14:0]           second_config;
  logic [10:0]           resistance_value, cnt;
  logic [7:0]            n_starts, a, n0;
  logic [6:0]            e;
  logic [3:0]            n;
  logic [1:0]            sel [5] = '{2'd0, 2'd1, 2'd2, 2'd3, 2'd1};
  mcr_pkg::mcr_reg_req_s reg_req;
  mcr_pkg::mcr_nv_cmd_s  nv_cmd;
  mcr_pkg::mcr_first_config_word_s first_config;
  int                    errors, n_tests, toggles, i;

  mcr_regs #(.TACH_DELAY_CYCLES(DLY)) u_mcr_regs (.sys_clk, .rst_b, .reg_req, .reg_rdata,
    .reg_rvalid, .nv_read_done, .nv_read_word, .nv_cmd, .motor_drive_off, .motor_run_enable,
    .first_config, .second_config, .resistance_value, .elec_edge, .closed_loop, .tach_output);
  mcr_nv_model u_mcr_nv_model (.sys_clk, .rst_b, .nv_cmd, .nv_read_done, .nv_read_word,
    .n_starts);

  // ------------------------------------------------------------
  // Clock, tach edge counter, helpers
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Count output changes; sampled at the edge so values are settled
  always @(posedge sys_clk) begin
    if (tach_output !== tach_q) toggles++;
    tach_q = tach_output;
  end

  // Software encoding of a resistance count: keep the top four bits
  function automatic logic [6:0] enc(input logic [10:0] c);
    logic [2:0] s;
    s = 3'd0;
    while ((c >> s) > 11'd15) s++;
    return {s, 4'(c >> s)};
  endfunction : enc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [15:0] v);
    @(posedge sys_clk);
    reg_req <= '{1'b0, 1'b1, ad, v};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    #1; // Outputs settled before the caller looks
  endtask : wr

  // Read takes one cycle; data checked in the valid cycle
  task automatic rdc(input string what, input logic [7:0] ad, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_req <= '{1'b1, 1'b0, ad, 16'h0000};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1;
    chk("read valid", 16'h0001, {15'h0000, reg_rvalid});
    chk(what, exp, reg_rdata);
  endtask : rdc

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Bounded wait for the model's read completion
  task automatic wait_done;
    int k;
    k = 0;
    while (nv_read_done !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (nv_read_done !== 1'b1) begin
      chk("read completion", 16'h0001, 16'h0000);
      end_of_test();
    end
  endtask : wait_done

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {errors, n_tests, toggles} = '0;
    {rst_b, elec_edge, closed_loop} = '0;
    reg_req = '0;
    void'($urandom(32'hc08d99f6));
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc("reset read data", 8'h36, 16'h0000);
    rdc("reset config", 8'h90, 16'h0000);
    chk("reset motor off", 16'h0000, {15'h0000, motor_drive_off});
    $display("test reset done");
    // Every dither and tach select code with random other fields
    for (i = 0; i < 16; i++) begin
      d = {i[3:0], 12'($urandom)};
      wr(8'h90, d);
      rdc("config read", 8'h90, d);
      chk("config fields", d, first_config);
      chk("resistance", {5'h00, ({7'h00, d[3:0]} << d[6:4])}, resistance_value);
    end
    for (i = 0; i < 6; i++) begin
      cnt = (i == 0) ? 11'h00f : (i == 1) ? 11'h010 : (i == 2) ? 11'h7ff : 11'($urandom);
      d = {9'h000, enc(cnt)};
      wr(8'h90, d);
      chk("encoded resistance", {5'h00, (cnt >> d[6:4]) << d[6:4]}, resistance_value);
    end
    wr(8'h91, 16'hffff);
    chk("second config out", 16'h7fff, {1'b0, second_config});
    rdc("second config", 8'h91, 16'h7fff);
    $display("test config done");
    // Unused windows, corners first; nothing else may change
    for (i = 0; i < 12; i++) begin
      a = (i < 4) ? ((i < 2) ? 8'h37 + 8'(i * 40) : 8'h61 + 8'((i - 2) * 46))
        : (i[0] ? 8'h61 + 8'($urandom % 47) : 8'h37 + 8'($urandom % 41));
      wr(a, 16'($urandom));
      rdc("unused read", a, 16'h0000);
    end
    chk("config kept", d, first_config);
    $display("test unused done");
    // Single reads with the drive stopped, as programming requires
    wr(8'h60, 16'h8000);
    chk("motor run", 16'h0000, {15'h0000, motor_run_enable});
    rdc("control read", 8'h60, 16'h0000);
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h90 : 8'($urandom);
      wr(8'h33, {8'h00, a});
      wr(8'h35, 16'h0001);
      wait_done();
      rdc("single read word", 8'h36, {~a, a});
      wr(8'h36, 16'($urandom));
      rdc("read-only word", 8'h36, {~a, a});
    end
    n0 = n_starts;
    for (i = 0; i < 4; i++) wr(8'h35, {13'h0000, i[0], i[1:0]});
    repeat (3) @(posedge sys_clk);
    chk("start count", {8'h00, n0 + 8'd3}, {8'h00, n_starts});
    $display("test memory done");
    // Tach gating cases, each from a cleared divider
    for (i = 0; i < 5; i++) begin
      n = 4'($urandom);
      closed_loop <= (i == 4);
      wr(8'h60, 16'h8000);
      wr(8'h90, {2'b00, sel[i], n, 8'h00});
      wr(8'h60, 16'h0000);
      if (i == 4) repeat (DLY + 5) @(posedge sys_clk);
      toggles = 0;
      for (e = 0; e < 7'(4 * (n + 1)); e++) begin
        @(posedge sys_clk) elec_edge <= 1'b1;
        @(posedge sys_clk) elec_edge <= 1'b0;
      end
      repeat (4) @(posedge sys_clk);
      chk("tach toggles", (i == 1 || i == 3) ? 16'd0 : 16'd4, 16'(toggles));
    end
    $display("test tach done");
    end_of_test();
  end
endmodule : testbench
